// [verilog/ard_datapath.v]
/*
 * accumulator register datapath: accumulator, memory buffer, program
 * counter, shift counter, instruction register, parallel adder, serial
 * adder and the timed add/subtract/multiply/divide engine.
 * assumes a control sequencer drives the one-cycle enables below and
 * that core memory sits on the far side of the buffer register.
 */
`timescale 1ns/1ps
`include "ard_defs.vh"

module ard_datapath (
   input  wire                clk,
   input  wire                srst,
   // core memory side
   input  wire [`ARD_W-1:0]   mem_rdata,
   input  wire                b_ld_mem,
   output wire [`ARD_W-1:0]   mem_wdata,
   input  wire                mab_sel_i,
   output wire [`ARD_PW-1:0]  mem_addr,
   // parallel adder control
   input  wire [2:0]          add_fn,
   input  wire [1:0]          add_x_sel,
   input  wire [1:0]          add_y_sel,
   input  wire                a_ld_add,
   input  wire                b_ld_add,
   input  wire                i_ld_add,
   input  wire                i_rel_ld,
   // serial shift control
   input  wire                shift_en,
   input  wire [1:0]          shift_mode,
   input  wire                shift_b22,
   input  wire                ser_bit,
   input  wire                ser_carry_clr,
   // counter and instruction register control
   input  wire                p_inc1,
   input  wire                p_inc2,
   input  wire                p_ld_i,
   input  wire                j_inc,
   input  wire                j_ld_icompl,
   input  wire                i_ld_fetch,
   input  wire                i_ld_b,
   input  wire                i_ld_j,
   // timed arithmetic
   input  wire                op_start,
   input  wire [1:0]          op_code,
   output wire                op_busy,
   output reg                 op_done,
   // register contents and parallel adder carry
   output wire [`ARD_W-1:0]   a_out,
   output wire [`ARD_PW-1:0]  p_out,
   output wire [`ARD_JW-1:0]  j_out,
   output wire [`ARD_W-1:0]   i_out,
   output wire                i_rel,
   output wire                add_carry
);

   // whole-number cycle counts, cut to the counter width on purpose
   localparam integer       N_ADD   = `ARD_CYC_ADD;
   localparam integer       N_MUL   = `ARD_CYC_MULMIN;
   localparam integer       N_DIV   = `ARD_CYC_DIV;
   localparam [`ARD_TW-1:0] CYC_ADD = N_ADD[`ARD_TW-1:0];
   localparam [`ARD_TW-1:0] CYC_MUL = N_MUL[`ARD_TW-1:0];
   localparam [`ARD_TW-1:0] CYC_DIV = N_DIV[`ARD_TW-1:0];
   localparam               ST_IDLE = 1'b0;
   localparam               ST_RUN  = 1'b1;

   reg  [`ARD_W-1:0]  a_reg;
   reg  [`ARD_W-1:0]  a_next;
   reg  [`ARD_W-1:0]  b_reg;
   reg  [`ARD_W-1:0]  b_next;
   reg  [`ARD_W-1:0]  i_reg;
   reg  [`ARD_W-1:0]  i_next;
   reg                i_rel_reg;
   reg  [`ARD_PW-1:0] p_reg;
   reg  [`ARD_PW-1:0] p_next;
   reg  [`ARD_JW-1:0] j_reg;
   reg  [`ARD_JW-1:0] j_next;
   reg  [`ARD_PW-1:0] mab_reg;
   reg                ser_carry_reg;
   reg                ser_carry_next;
   reg                ser_sum;
   reg                st_reg;
   reg  [`ARD_TW-1:0] cnt_reg;
   reg  [1:0]         opc_reg;
   reg  [`ARD_W-1:0]  add_x;
   reg  [`ARD_W-1:0]  add_y;
   reg  [`ARD_W:0]    add_sum;
   reg  [`ARD_W-1:0]  add_res;
   reg  [`ARD_W-1:0]  op_a;
   reg  [`ARD_W-1:0]  op_b;

   wire               idle = (st_reg == ST_IDLE);
   wire               fin  = (st_reg == ST_RUN) && (cnt_reg == 11'h001);

   // signed operands for the timed engine
   wire signed [47:0] mul_prod = $signed(i_reg) * $signed(b_reg);
   wire signed [46:0] div_dvd  = $signed({a_reg, b_reg[`ARD_W-2:0]});
   wire signed [46:0] div_dvs  = {{23{i_reg[`ARD_W-1]}}, i_reg};
   wire               div_zero = (i_reg == `ARD_RST_WORD);
   wire signed [46:0] div_quo  = div_zero ? 47'sh0 : div_dvd / div_dvs;
   wire signed [46:0] div_rem  = div_zero ? div_dvd : div_dvd % div_dvs;

   assign mem_wdata = b_reg;
   assign mem_addr  = mab_reg;
   assign a_out     = a_reg;
   assign p_out     = p_reg;
   assign j_out     = j_reg;
   assign i_out     = i_reg;
   assign i_rel     = i_rel_reg;
   assign add_carry = add_sum[`ARD_W];
   assign op_busy   = ~idle;

   ////////////////////////////////////////////////////////////////////
   // parallel adder operand selection and function
   always @* begin
      if (add_x_sel == `ARD_X_A) begin
         add_x = a_reg;
      end else if (add_x_sel == `ARD_X_I) begin
         add_x = i_reg;
      end else if (add_x_sel == `ARD_X_P) begin
         add_x = {{(`ARD_W-`ARD_PW){1'b0}}, p_reg};
      end else begin
         add_x = `ARD_RST_WORD;
      end
      if (add_y_sel == `ARD_Y_BFULL) begin
         add_y = b_reg;
      end else if (add_y_sel == `ARD_Y_BADDR) begin
         add_y = {10'h000, b_reg[`ARD_ADDR_MSB:0]};
      end else if (add_y_sel == `ARD_Y_I) begin
         add_y = i_reg;
      end else begin
         add_y = `ARD_RST_WORD;
      end
      add_sum = {1'b0, add_x} + {1'b0, add_y};
      case (add_fn)
         `ARD_FN_SUB: add_sum = {1'b0, add_x} + {1'b0, ~add_y} + 25'h0000001;
         `ARD_FN_XOR: add_sum = {1'b0, add_x ^ add_y};
         `ARD_FN_AND: add_sum = {1'b0, add_x & add_y};
         `ARD_FN_OR:  add_sum = {1'b0, add_x | add_y};
         default:     add_sum = {1'b0, add_x} + {1'b0, add_y};
      endcase
      add_res = add_sum[`ARD_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////
   // timed engine results for add and subtract
   always @* begin
      op_a = a_reg + b_reg;
      op_b = a_reg - b_reg;
   end

   ////////////////////////////////////////////////////////////////////
   // next values of accumulator, buffer and serial adder
   always @* begin
      a_next         = a_reg;
      b_next         = b_reg;
      ser_carry_next = ser_carry_reg;
      ser_sum        = 1'b0;
      if (fin) begin
         if (opc_reg == `ARD_OP_ADD) begin
            a_next = op_a;
         end else if (opc_reg == `ARD_OP_SUB) begin
            a_next = op_b;
         end else if (opc_reg == `ARD_OP_MUL) begin
            a_next = mul_prod[46:23];
            b_next = {mul_prod[47], mul_prod[22:0]};
         end else begin
            a_next = div_quo[`ARD_W-1:0];
            b_next = div_rem[`ARD_W-1:0];
         end
      end else if (idle && shift_en) begin
         case (shift_mode)
            `ARD_SH_RCIRC: begin
               // serial adder on A0, result back to A23; circular
               // rotation also gives the micro-coded left shift
               ser_sum        = a_reg[0] ^ ser_bit ^ ser_carry_reg;
               ser_carry_next = (a_reg[0] & ser_bit) |
                                (ser_carry_reg & (a_reg[0] ^ ser_bit));
               a_next         = {ser_sum, a_reg[`ARD_W-1:1]};
            end
            `ARD_SH_RARI: begin
               ser_sum        = a_reg[23] ^ ser_bit ^ ser_carry_reg;
               ser_carry_next = (a_reg[23] & ser_bit) |
                                (ser_carry_reg & (a_reg[23] ^ ser_bit));
               a_next         = {ser_sum, a_reg[23], a_reg[22:1]};
            end
            `ARD_SH_RDBL: begin
               a_next = {a_reg[23], a_reg[23:1]};
               if (shift_b22) begin
                  b_next = {b_reg[23], a_reg[0], b_reg[22:1]};
               end else begin
                  b_next = {a_reg[0], b_reg[23:1]};
               end
            end
            default: begin
               // true left shift; old A23 falls off
               a_next = {a_reg[22:0], shift_b22 ? b_reg[22] : b_reg[23]};
               if (shift_b22) begin
                  b_next = {b_reg[23], b_reg[21:0], 1'b0};
               end else begin
                  b_next = {b_reg[22:0], 1'b0};
               end
            end
         endcase
      end else if (idle) begin
         if (a_ld_add) begin
            a_next = add_res;
         end
         if (b_ld_add) begin
            b_next = add_res;
         end else if (b_ld_mem) begin
            b_next = mem_rdata;
         end
      end
      if (ser_carry_clr) begin
         ser_carry_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next values of instruction register and counters
   always @* begin
      i_next = i_reg;
      p_next = p_reg;
      j_next = j_reg;
      if (idle) begin
         if (i_ld_add) begin
            i_next = add_res;
         end else if (i_ld_b) begin
            i_next = b_reg;
         end else if (i_ld_fetch) begin
            i_next = {b_reg[23:`ARD_FETCH_LO], i_reg[`ARD_FETCH_LO-1:0]};
         end else if (i_ld_j) begin
            i_next = {i_reg[23:`ARD_JW], j_reg};
         end
         if (p_ld_i) begin
            p_next = i_reg[`ARD_PW-1:0];
         end else if (p_inc2) begin
            p_next = p_reg + 15'h0002;
         end else if (p_inc1) begin
            p_next = p_reg + 15'h0001;
         end
         if (j_ld_icompl) begin
            j_next = ~i_reg[`ARD_JW-1:0];
         end else if (j_inc) begin
            j_next = j_reg + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register update and initialize
   always @(posedge clk) begin
      if (srst) begin
         a_reg         <= `ARD_RST_WORD;
         b_reg         <= `ARD_RST_WORD;
         i_reg         <= `ARD_RST_WORD;
         i_rel_reg     <= 1'b0;
         p_reg         <= `ARD_RST_P;
         j_reg         <= `ARD_RST_J;
         mab_reg       <= `ARD_RST_P;
         ser_carry_reg <= 1'b0;
      end else begin
         a_reg         <= a_next;
         b_reg         <= b_next;
         i_reg         <= i_next;
         p_reg         <= p_next;
         j_reg         <= j_next;
         ser_carry_reg <= ser_carry_next;
         mab_reg       <= mab_sel_i ? i_next[`ARD_PW-1:0] : p_next;
         if (idle && i_rel_ld) begin
            i_rel_reg <= add_sum[`ARD_FETCH_LO];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // timed arithmetic sequencer
   always @(posedge clk) begin
      if (srst) begin
         st_reg  <= ST_IDLE;
         cnt_reg <= 11'h000;
         opc_reg <= `ARD_OP_ADD;
         op_done <= 1'b0;
      end else begin
         op_done <= fin;
         case (st_reg)
            ST_IDLE: begin
               if (op_start) begin
                  st_reg  <= ST_RUN;
                  opc_reg <= op_code;
                  if (op_code == `ARD_OP_MUL) begin
                     cnt_reg <= CYC_MUL;
                  end else if (op_code == `ARD_OP_DIV) begin
                     cnt_reg <= CYC_DIV;
                  end else begin
                     cnt_reg <= CYC_ADD;
                  end
               end
            end
            default: begin
               cnt_reg <= cnt_reg - 11'h001;
               if (fin) begin
                  st_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

// [inc/ard_defs.vh]
/*
 * constants for the accumulator register datapath: widths, select codes,
 * command encodings and operation timing counts.
 * assumes a single 125 MHz clock with an 8 ns period.
 */
`ifndef ARD_DEFS_VH
`define ARD_DEFS_VH

// widths
`define ARD_W        24
`define ARD_PW       15
`define ARD_JW       5
`define ARD_TW       11

// reset value of the word registers, program counter, address register and shift counter
`define ARD_RST_WORD 24'h000000
`define ARD_RST_P    15'h0000
`define ARD_RST_J    5'h00

// field positions
`define ARD_FETCH_LO 14
`define ARD_ADDR_MSB 13

// parallel adder function codes
`define ARD_FN_ADD   3'h0
`define ARD_FN_SUB   3'h1
`define ARD_FN_XOR   3'h2
`define ARD_FN_AND   3'h3
`define ARD_FN_OR    3'h4

// parallel adder x operand select
`define ARD_X_A      2'h0
`define ARD_X_I      2'h1
`define ARD_X_P      2'h2
`define ARD_X_ZERO   2'h3

// parallel adder y operand select
`define ARD_Y_BFULL  2'h0
`define ARD_Y_BADDR  2'h1
`define ARD_Y_I      2'h2
`define ARD_Y_ZERO   2'h3

// serial shift modes
`define ARD_SH_RCIRC 2'h0
`define ARD_SH_RARI  2'h1
`define ARD_SH_RDBL  2'h2
`define ARD_SH_LDBL  2'h3

// timed arithmetic commands
`define ARD_OP_ADD   2'h0
`define ARD_OP_SUB   2'h1
`define ARD_OP_MUL   2'h2
`define ARD_OP_DIV   2'h3

// operation times in ns and the cycle counts derived from them
`define ARD_CLK_NS      8
`define ARD_T_ADD_NS    3200
`define ARD_T_MULMIN_NS 8900
`define ARD_T_MULMAX_NS 12100
`define ARD_T_DIV_NS    13600
`define ARD_CYC_ADD    ((`ARD_T_ADD_NS + `ARD_CLK_NS - 1) / `ARD_CLK_NS)
`define ARD_CYC_MULMIN ((`ARD_T_MULMIN_NS + `ARD_CLK_NS - 1) / `ARD_CLK_NS)
`define ARD_CYC_MULMAX (`ARD_T_MULMAX_NS / `ARD_CLK_NS)
`define ARD_CYC_DIV    ((`ARD_T_DIV_NS + `ARD_CLK_NS - 1) / `ARD_CLK_NS)

`endif

// [test/ard_core_mem.sv]
/* core memory stand-in for the datapath: a fixed word per address.
   assumes reads are combinational from the registered address. */
`timescale 1ns/1ps
module ard_core_mem (
   input  wire [14:0] mem_addr,
   output wire [23:0] mem_rdata
);
   // word depends on the low address nibble so neighbours differ
   assign mem_rdata = 24'hC35A96 ^ {6{mem_addr[3:0]}};
endmodule

// [test/ard_dp_asserts.sv]
/* concurrent checks on the ports of the accumulator register datapath.
   assumes one clock and the synchronous active-high initialize. */
`timescale 1ns/1ps
`include "ard_defs.vh"
module ard_dp_asserts (
   input wire                clk,
   input wire                srst,
   input wire [`ARD_W-1:0]   mem_wdata,
   input wire [2:0]          add_fn,
   input wire [1:0]          add_x_sel,
   input wire [1:0]          add_y_sel,
   input wire                a_ld_add,
   input wire                shift_en,
   input wire [1:0]          shift_mode,
   input wire                shift_b22,
   input wire                p_inc1,
   input wire                p_inc2,
   input wire                p_ld_i,
   input wire                j_ld_icompl,
   input wire                op_start,
   input wire [1:0]          op_code,
   input wire                op_busy,
   input wire                op_done,
   input wire [`ARD_W-1:0]   a_out,
   input wire [`ARD_PW-1:0]  p_out,
   input wire [`ARD_JW-1:0]  j_out,
   input wire [`ARD_W-1:0]   i_out
);
   reg  [10:0] cnt_reg;
   reg  [1:0]  code_reg;
   wire [10:0] lim = (code_reg == `ARD_OP_MUL) ? `ARD_CYC_MULMIN :
                     (code_reg == `ARD_OP_DIV) ? `ARD_CYC_DIV : `ARD_CYC_ADD;
   // busy sample count and the command of the running operation
   always @(posedge clk) begin
      cnt_reg <= (srst || !op_busy) ? 11'h000 : cnt_reg + 11'h001;
      code_reg <= srst ? 2'h0 : ((op_start && !op_busy) ? op_code : code_reg);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence take_s; op_start && !op_busy; endsequence
   sequence finish_s; $fell(op_busy) && !$past(srst); endsequence
   ////////////////////////////////////////////////////////////////////////
   op_start_a: assert property (take_s |=> op_busy)
      else $error("timed op not started");
   op_len_a: assert property (finish_s |-> cnt_reg == lim)
      else $error("timed op length wrong");
   op_done_a: assert property (finish_s |-> op_done)
      else $error("done missing at end of op");
   done_once_a: assert property (op_done |-> $fell(op_busy))
      else $error("done without end of op");
   a_sum_a: assert property (a_ld_add && !op_busy && !shift_en &&
      add_fn == `ARD_FN_ADD && add_x_sel == `ARD_X_A && add_y_sel == `ARD_Y_BFULL |=>
      a_out == $past(a_out) + $past(mem_wdata)) else $error("accumulator sum wrong");
   p_step_a: assert property (p_inc1 && !p_inc2 && !p_ld_i && !op_busy |=>
      p_out == $past(p_out) + 15'h0001) else $error("program count step wrong");
   p_two_a: assert property (p_inc2 && !p_ld_i && !op_busy |=>
      p_out == $past(p_out) + 15'h0002) else $error("program count double step wrong");
   p_branch_a: assert property (p_ld_i && !op_busy |=> p_out == $past(i_out[14:0]))
      else $error("branch load wrong");
   j_load_a: assert property (j_ld_icompl && !op_busy |=> j_out == ~$past(i_out[4:0]))
      else $error("shift counter complement load wrong");
   left_a: assert property (shift_en && shift_mode == `ARD_SH_LDBL &&
      !shift_b22 && !op_busy |=> a_out == {$past(a_out[22:0]), $past(mem_wdata[23])})
      else $error("left shift wrong");
   right_b_a: assert property (shift_en && shift_mode == `ARD_SH_RDBL &&
      !shift_b22 && !op_busy |=> mem_wdata == {$past(a_out[0]), $past(mem_wdata[23:1])})
      else $error("buffer extension shift wrong");
   refuse_a: assert property (op_busy && (p_inc1 || p_inc2 || p_ld_i) |=> $stable(p_out))
      else $error("program counter moved while busy");
endmodule
bind ard_datapath ard_dp_asserts u_chk (.clk(clk), .srst(srst), .mem_wdata(mem_wdata),
   .add_fn(add_fn), .add_x_sel(add_x_sel), .add_y_sel(add_y_sel), .a_ld_add(a_ld_add),
   .shift_en(shift_en), .shift_mode(shift_mode), .shift_b22(shift_b22), .p_inc1(p_inc1),
   .p_inc2(p_inc2), .p_ld_i(p_ld_i), .j_ld_icompl(j_ld_icompl), .op_start(op_start),
   .op_code(op_code), .op_busy(op_busy), .op_done(op_done), .a_out(a_out), .p_out(p_out),
   .j_out(j_out), .i_out(i_out));

// [test/accumulator_register_datapath_tb.sv]
/* self-checking bench for the accumulator register datapath.
   assumes the datapath, the memory stand-in and the checker are compiled. */
`timescale 1ns/1ps
`include "ard_defs.vh"
module accumulator_register_datapath_tb;
   typedef struct packed {logic [2:0] fn; logic [1:0] x; logic [1:0] y; logic [23:0] e;} ard_row_t;
   localparam logic [23:0] WA = 24'hC35A96; // word at address 0
   localparam logic [23:0] WB = 24'hD24B87; // word at address 1
   localparam ard_row_t ROWS [9] = '{
      '{`ARD_FN_ADD, `ARD_X_A, `ARD_Y_BFULL, WA + WB}, '{`ARD_FN_SUB, `ARD_X_A, `ARD_Y_BFULL, WA - WB},
      '{`ARD_FN_XOR, `ARD_X_A, `ARD_Y_BFULL, WA ^ WB}, '{`ARD_FN_AND, `ARD_X_A, `ARD_Y_BFULL, WA & WB},
      '{`ARD_FN_OR, `ARD_X_A, `ARD_Y_BFULL, WA | WB},
      '{`ARD_FN_ADD, `ARD_X_ZERO, `ARD_Y_BADDR, {10'h000, WB[13:0]}},
      '{`ARD_FN_ADD, `ARD_X_P, `ARD_Y_ZERO, 24'h000001}, '{`ARD_FN_ADD, `ARD_X_I, `ARD_Y_ZERO, 24'h000001},
      '{`ARD_FN_SUB, `ARD_X_ZERO, `ARD_Y_I, 24'hFFFFFF}};
   logic               clk, srst, mab_sel_i, shift_b22, ser_bit;
   logic [15:0]        st;
   logic [2:0]         add_fn;
   logic [1:0]         add_x_sel, add_y_sel, shift_mode, op_code;
   wire  [23:0]        mem_rdata, mem_wdata, a_out, i_out;
   wire  [14:0]        mem_addr, p_out;
   wire  [4:0]         j_out;
   wire                op_busy, op_done, i_rel, add_carry;
   logic [23:0]        ea, eb, ei;
   logic signed [47:0] prod;
   logic signed [46:0] dd, q, r;
   int                 num_errors, n_compared, n, c;
   ard_datapath u_dut (.clk(clk), .srst(srst), .mem_rdata(mem_rdata), .b_ld_mem(st[0]),
      .mem_wdata(mem_wdata), .mab_sel_i(mab_sel_i), .mem_addr(mem_addr), .add_fn(add_fn),
      .add_x_sel(add_x_sel), .add_y_sel(add_y_sel), .a_ld_add(st[1]), .b_ld_add(st[2]),
      .i_ld_add(st[3]), .i_rel_ld(st[4]), .shift_en(st[5]), .shift_mode(shift_mode),
      .shift_b22(shift_b22), .ser_bit(ser_bit), .ser_carry_clr(st[6]), .p_inc1(st[7]),
      .p_inc2(st[8]), .p_ld_i(st[9]), .j_inc(st[10]), .j_ld_icompl(st[11]), .i_ld_fetch(st[12]),
      .i_ld_b(st[13]), .i_ld_j(st[14]), .op_start(st[15]), .op_code(op_code),
      .op_busy(op_busy), .op_done(op_done), .a_out(a_out), .p_out(p_out), .j_out(j_out),
      .i_out(i_out), .i_rel(i_rel), .add_carry(add_carry));
   ard_core_mem u_mem (.mem_addr(mem_addr), .mem_rdata(mem_rdata));
   // free-running 8 ns clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // hold one strobe pattern for one edge
   task automatic go(input logic [15:0] s);
      st = s;
      @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input int k);
      srst = 1'b1;
      repeat (k) go(16'h0000);
      srst = 1'b0;
      chk("rst_regs", {a_out, i_out}, 48'h0);
      chk("rst_ctrs", {p_out, j_out, mem_addr, op_busy, op_done, i_rel}, 48'h0);
      chk("rst_b", mem_wdata, 48'h0);
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {mab_sel_i, shift_b22, ser_bit, add_fn, add_x_sel, add_y_sel, shift_mode, op_code} = '0;
      num_errors = 0;
      n_compared = 0;
      do_reset(8);
      // b from word 0, a from b, then b from word 1
      go(16'h0001);
      add_x_sel = `ARD_X_ZERO;
      go(16'h0002);
      go(16'h0080);
      go(16'h0000);
      go(16'h0001);
      chk("a_load", a_out, WA);
      chk("b_load", mem_wdata, WB);
      chk("p_step", p_out, 15'h0001);
      // adder table into the instruction register, back to back
      foreach (ROWS[k]) begin
         add_fn = ROWS[k].fn;
         add_x_sel = ROWS[k].x;
         add_y_sel = ROWS[k].y;
         go(16'h0018);
         chk("adder", i_out, ROWS[k].e);
         chk("i_rel", i_rel, ROWS[k].e[14]);
         chk("carry", add_carry, k == 0);
      end
      add_fn = `ARD_FN_ADD;
      add_y_sel = `ARD_Y_ZERO;
      go(16'h2000);
      chk("i_from_b", i_out, WB);
      add_x_sel = `ARD_X_ZERO;
      go(16'h0008);
      go(16'h1000);
      chk("fetch", i_out, {WB[23:14], 14'h0000});
      go(16'h0800);
      chk("j_compl", j_out, 5'h1F);
      go(16'h0400);
      chk("j_wrap", j_out, 5'h00);
      go(16'h0400);
      go(16'h4000);
      ei = {WB[23:14], 14'h0001};
      chk("i_from_j", i_out, ei);
      go(16'h0200);
      chk("branch", p_out, ei[14:0]);
      go(16'h0100);
      chk("p_two", p_out, ei[14:0] + 15'h0002);
      mab_sel_i = 1'b1;
      go(16'h0000);
      chk("mab", mem_addr, ei[14:0]);
      mab_sel_i = 1'b0;
      // shift paths
      ea = WA;
      eb = WB;
      shift_mode = `ARD_SH_LDBL;
      go(16'h0020);
      ea = {ea[22:0], eb[23]};
      eb = {eb[22:0], 1'b0};
      chk("left", a_out, ea);
      shift_mode = `ARD_SH_RDBL;
      go(16'h0020);
      eb = {ea[0], eb[23:1]};
      ea = {ea[23], ea[23:1]};
      chk("right_ab", {a_out, mem_wdata}, {ea, eb});
      shift_b22 = 1'b1;
      go(16'h0020);
      eb = {eb[23], ea[0], eb[22:1]};
      ea = {ea[23], ea[23:1]};
      chk("right_ab22", {a_out, mem_wdata}, {ea, eb});
      shift_mode = `ARD_SH_LDBL;
      go(16'h0020);
      ea = {ea[22:0], eb[22]};
      eb = {eb[23], eb[21:0], 1'b0};
      chk("left22", a_out, ea);
      shift_b22 = 1'b0;
      shift_mode = `ARD_SH_RARI;
      go(16'h0040);
      go(16'h0020);
      ea = {ea[23], ea[23:1]};
      chk("right_arith", a_out, ea);
      shift_mode = `ARD_SH_RCIRC;
      ser_bit = 1'b1;
      go(16'h0020);
      ea = {~ea[0], ea[23:1]};
      chk("right_circ", a_out, ea);
      ser_bit = 1'b0;
      // timed add, subtract, multiply, divide with refused strobes meanwhile
      add_y_sel = `ARD_Y_BADDR;
      for (c = 0; c < 4; c++) begin
         if (c == 3) begin
            go(16'h0002);
            ea = {10'h000, eb[13:0]};
         end
         op_code = c[1:0];
         prod = $signed(ei) * $signed(eb);
         dd = {ea, eb[22:0]};
         q = dd / $signed(ei);
         r = dd % $signed(ei);
         case (c)
            0: ea = ea + eb;
            1: ea = ea - eb;
            2: {ea, eb} = {prod[46:23], prod[47], prod[22:0]};
            default: {ea, eb} = {q[23:0], r[23:0]};
         endcase
         go(16'h8000);
         go(16'h8080);
         n = 1;
         while (op_done !== 1'b1 && n < 3000) begin
            go(16'h0000);
            n++;
         end
         if (n == 3000) begin
            num_errors++;
            break;
         end
         chk("op_len", n, (c == 2) ? `ARD_CYC_MULMIN : (c == 3) ? `ARD_CYC_DIV : `ARD_CYC_ADD);
         chk("op_result", {a_out, mem_wdata}, {ea, eb});
         chk("p_refused", p_out, ei[14:0] + 15'h0002);
      end
      // accumulate a plus b through the adder
      add_x_sel = `ARD_X_A;
      add_y_sel = `ARD_Y_BFULL;
      go(16'h0002);
      ea = ea + eb;
      chk("a_acc", a_out, ea);
      do_reset(2);
      end_of_test();
   end
endmodule
